/* File: hw/hcr_cfg.svh */
// Purpose: Register offsets and reset values of the compare/reset block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   Included by the package and the top module
`ifndef HCR_CFG_SVH
`define HCR_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define HCR_OFF_CTRL      8'h00
`define HCR_OFF_OUT       8'h04
`define HCR_OFF_CMP       8'h08
`define HCR_OFF_ZLO       8'h0C
`define HCR_OFF_ZHI       8'h10
`define HCR_OFF_G1_MODE   8'h14
`define HCR_OFF_G4_MODE   8'h18
`define HCR_OFF_AB_MULT   8'h1C
`define HCR_OFF_CAPA_LO   8'h20
`define HCR_OFF_CAPA_HI   8'h24
`define HCR_OFF_CAPB_LO   8'h28
`define HCR_OFF_CAPB_HI   8'h2C
`define HCR_OFF_CNT0      8'h30
`define HCR_OFF_CNT1      8'h34
`define HCR_OFF_CNTSW     8'h38
`define HCR_OFF_STATUS    8'h3C

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HCR_RST_CTRL      32'h01F80000
`define HCR_RST_MODE      16'h0002
`define HCR_RST_AB_MULT   16'h0004
`define HCR_RST_OUT       8'h00

// ----------------------------------------------------------------
// Mode codes and zone geometry
// ----------------------------------------------------------------
`define HCR_MODE_X1       16'h0001
`define HCR_MODE_X2       16'h0002
`define HCR_MODE_X3       16'h0003
`define HCR_ZONE_BITS     3
`define HCR_OUT_BITS      8

`endif

/* File: hw/hcr_pkg.sv */
// Purpose: Types shared by the compare/reset block
// Assumes: hcr_cfg.svh holds the numbers
// Notes:   Control word layout matches the CTRL register bit for bit
`include "hcr_cfg.svh"

package hcr_pkg;

	// ------------------------------------------------------------
	// Counter selection, control word and pin bundle
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		SEL_HW0,
		SEL_HW1,
		SEL_SW,
		SEL_NONE
	} hcr_sel_e;

	typedef struct packed {
		logic [2:0] rsvd;
		logic       sw_reset_ctrl;
		logic       sw_start_ctrl;
		logic       sw_start_reset_enable;
		logic       sw_edge_fall;
		logic [1:0] dis_ext_start;
		logic [1:0] dis_ext_reset;
		logic [1:0] hw_int_start;
		logic [1:0] hw_int_reset;
		logic [2:0] zone_base;
		hcr_sel_e   zone_cnt_sel;
		logic       zone_en;
		logic [2:0] irq_inhibit;
		logic       immediate_ext_reset_flag;
		hcr_sel_e   cr_cnt_sel;
		logic [2:0] cr_out_sel;
		logic       cr_self;
		logic       cr_en;
	} hcr_ctrl_s;

	typedef struct packed {
		logic [1:0] phase_a;
		logic [1:0] phase_b;
		logic [1:0] ext_reset;
		logic [1:0] ext_start;
		logic [1:0] cap_evt;
		logic       sw_pulse;
	} hcr_pins_s;

	typedef logic [31:0] hcr_word_t;

endpackage : hcr_pkg

/* File: hw/hcr_top.sv */
// Purpose: Compare-reset, zone compare and capture for fast counters
// Assumes: Pins are asynchronous; APB master on pclk
// Notes:   Two hardware counters and one software counter
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "hcr_cfg.svh"

// ----------------------------------------------------------------
// Pin synchroniser with agreement filter
// ----------------------------------------------------------------
module hcr_sync #(
	parameter int W = 1
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s0_q;
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s0_q <= '0;
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s0_q <= din;
			s1_q <= s0_q;
			s2_q <= s1_q;
		end
	end

	// Glitch filter: accept a level only once two stages agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= '0;
		end else begin
			for (int i = 0; i < W; i++) begin
				if (s1_q[i] == s2_q[i]) begin
					dout[i] <= s2_q[i];
				end
			end
		end
	end
endmodule : hcr_sync

// ----------------------------------------------------------------
// Top
// ----------------------------------------------------------------
module hcr_top
	import hcr_pkg::*;
#(
	parameter int CW = 32
) (
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire hcr_pins_s             pins,
	output logic [`HCR_OUT_BITS-1:0]   out_q,
	output logic                       cmp_irq_q
);

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	hcr_pins_s          pf;
	hcr_pins_s          pp_q;
	hcr_ctrl_s          ctrl_q;
	logic [CW-1:0]      cmp_q;
	logic [CW-1:0]      zlo_q;
	logic [CW-1:0]      zhi_q;
	logic [15:0]        g1_mode_q;
	logic [15:0]        g4_mode_q;
	logic [15:0]        ab_mult_q;
	logic [CW-1:0]      cap_q   [2];
	logic [CW-1:0]      cnt_q   [3];
	logic [CW-1:0]      prev_q  [3];
	logic [2:0]         rst_q;
	logic [2:0]         rst_p_q;
	logic [2:0]         self_clr;
	logic [2:0]         zone_q;
	logic [2:0]         zone_d;
	logic [31:0]        rdata_d;
	logic               rd_ok;
	logic               wr_en;
	logic [CW-1:0]      cr_val;
	logic [CW-1:0]      cr_prev;
	logic               cr_valid;
	logic               cr_hw;
	logic               eq_evt;
	logic               imm_evt;
	logic [CW-1:0]      zv;
	logic               zvalid;

	hcr_sync #(
		.W       ($bits(hcr_pins_s))
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (pins),
		.dout    (pf)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pp_q <= '0;
		end else begin
			pp_q <= pf;
		end
	end

	// ------------------------------------------------------------
	// APB slave, one access cycle without wait
	// ------------------------------------------------------------
	assign wr_en = psel & penable & pready & pwrite;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= '0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			prdata  <= (psel & ~penable & ~pwrite) ? rdata_d : '0;
			pslverr <= psel & ~penable & ~rd_ok;
		end
	end

	always_comb begin
		rdata_d = '0;
		rd_ok   = 1'b1;
		unique case (paddr)
			`HCR_OFF_CTRL:    rdata_d = ctrl_q;
			`HCR_OFF_OUT:     rdata_d = {24'h000000, out_q};
			`HCR_OFF_CMP:     rdata_d = cmp_q;
			`HCR_OFF_ZLO:     rdata_d = zlo_q;
			`HCR_OFF_ZHI:     rdata_d = zhi_q;
			`HCR_OFF_G1_MODE: rdata_d = {16'h0000, g1_mode_q};
			`HCR_OFF_G4_MODE: rdata_d = {16'h0000, g4_mode_q};
			`HCR_OFF_AB_MULT: rdata_d = {16'h0000, ab_mult_q};
			`HCR_OFF_CAPA_LO: rdata_d = {16'h0000, cap_q[0][15:0]};
			`HCR_OFF_CAPA_HI: rdata_d = {16'h0000, cap_q[0][31:16]};
			`HCR_OFF_CAPB_LO: rdata_d = {16'h0000, cap_q[1][15:0]};
			`HCR_OFF_CAPB_HI: rdata_d = {16'h0000, cap_q[1][31:16]};
			`HCR_OFF_CNT0:    rdata_d = cnt_q[0];
			`HCR_OFF_CNT1:    rdata_d = cnt_q[1];
			`HCR_OFF_CNTSW:   rdata_d = cnt_q[2];
			`HCR_OFF_STATUS:  rdata_d = {29'h0000000, zone_q};
			default:          rd_ok   = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// Software-written configuration
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q    <= hcr_ctrl_s'(`HCR_RST_CTRL);
			cmp_q     <= '0;
			zlo_q     <= '0;
			zhi_q     <= '0;
			g1_mode_q <= `HCR_RST_MODE;
			g4_mode_q <= `HCR_RST_MODE;
			ab_mult_q <= `HCR_RST_AB_MULT;
		end else if (wr_en) begin
			unique case (paddr)
				`HCR_OFF_CTRL:    ctrl_q    <= hcr_ctrl_s'(pwdata);
				`HCR_OFF_CMP:     cmp_q     <= pwdata;
				`HCR_OFF_ZLO:     zlo_q     <= pwdata;
				`HCR_OFF_ZHI:     zhi_q     <= pwdata;
				`HCR_OFF_G1_MODE: g1_mode_q <= pwdata[15:0];
				`HCR_OFF_G4_MODE: g4_mode_q <= pwdata[15:0];
				`HCR_OFF_AB_MULT: ab_mult_q <= pwdata[15:0];
				default:          ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Hardware counters with quadrature decode
	// ------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_hw
		logic        a_e;
		logic        b_e;
		logic        step;
		logic        up;
		logic        run;
		logic        clr;
		logic        rst_lvl;
		logic [15:0] mode;

		assign mode = (i == 0) ? g1_mode_q : g4_mode_q;
		assign a_e  = pf.phase_a[i] ^ pp_q.phase_a[i];
		assign b_e  = pf.phase_b[i] ^ pp_q.phase_b[i];
		// A leading B counts up
		assign up   = pf.phase_a[i] ^ pp_q.phase_b[i];

		always_comb begin
			unique case (mode)
				`HCR_MODE_X1: step = a_e & pf.phase_a[i];
				`HCR_MODE_X2: step = a_e;
				`HCR_MODE_X3: step = a_e | (b_e & pf.phase_b[i]);
				default:      step = a_e | b_e;
			endcase
		end

		assign rst_lvl = ctrl_q.dis_ext_reset[i] ? ctrl_q.hw_int_reset[i]
			: pf.ext_reset[i];
		assign run     = ctrl_q.dis_ext_start[i] ? ctrl_q.hw_int_start[i]
			: pf.ext_start[i];
		assign clr     = rst_lvl | self_clr[i];

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cnt_q[i] <= '0;
			end else if (clr) begin
				cnt_q[i] <= '0;
			end else if (run & step) begin
				cnt_q[i] <= up ? cnt_q[i] + 1'b1 : cnt_q[i] - 1'b1;
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rst_q[i] <= 1'b0;
			end else begin
				rst_q[i] <= rst_lvl;
			end
		end

		// Capture happens on the rising edge of the event pin
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cap_q[i] <= '0;
			end else if (pf.cap_evt[i] & ~pp_q.cap_evt[i]) begin
				cap_q[i] <= cnt_q[i];
			end
		end
	end

	// ------------------------------------------------------------
	// Software counter
	// ------------------------------------------------------------
	logic sw_edge;
	logic sw_run;
	logic sw_rst;

	assign sw_edge = ctrl_q.sw_edge_fall
		? (pp_q.sw_pulse & ~pf.sw_pulse)
		: (pf.sw_pulse & ~pp_q.sw_pulse);
	assign sw_run  = ~ctrl_q.sw_start_reset_enable
		| ctrl_q.sw_start_ctrl;
	assign sw_rst  = ctrl_q.sw_start_reset_enable
		& ctrl_q.sw_reset_ctrl;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q[2] <= '0;
			rst_q[2] <= 1'b0;
		end else begin
			rst_q[2] <= sw_rst;
			if (sw_rst | self_clr[2]) begin
				cnt_q[2] <= '0;
			end else if (sw_run & sw_edge) begin
				cnt_q[2] <= cnt_q[2] + 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int k = 0; k < 3; k++) begin
				prev_q[k] <= '0;
			end
			rst_p_q <= '0;
		end else begin
			for (int k = 0; k < 3; k++) begin
				prev_q[k] <= cnt_q[k];
			end
			rst_p_q <= rst_q;
		end
	end

	// ------------------------------------------------------------
	// Compare-reset
	// ------------------------------------------------------------
	always_comb begin
		cr_val   = '0;
		cr_prev  = '0;
		cr_valid = 1'b1;
		cr_hw    = 1'b0;
		unique case (ctrl_q.cr_cnt_sel)
			SEL_HW0: begin
				cr_val  = cnt_q[0];
				cr_prev = prev_q[0];
				cr_hw   = 1'b1;
			end
			SEL_HW1: begin
				cr_val  = cnt_q[1];
				cr_prev = prev_q[1];
				cr_hw   = 1'b1;
			end
			SEL_SW: begin
				cr_val  = cnt_q[2];
				cr_prev = prev_q[2];
			end
			SEL_NONE: cr_valid = 1'b0;
		endcase
	end

	// A change caused by a reset is not a counted arrival
	assign eq_evt  = cr_valid & (cr_val != cr_prev) & (cr_val == cmp_q)
		& ~rst_q[ctrl_q.cr_cnt_sel];
	assign imm_evt = ctrl_q.immediate_ext_reset_flag & cr_hw
		& rst_q[ctrl_q.cr_cnt_sel]
		& ~rst_p_q[ctrl_q.cr_cnt_sel];

	always_comb begin
		self_clr = '0;
		if (ctrl_q.cr_en & ctrl_q.cr_self & eq_evt) begin
			self_clr[ctrl_q.cr_cnt_sel] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_irq_q <= 1'b0;
		end else begin
			cmp_irq_q <= ctrl_q.cr_en & eq_evt
				& ~ctrl_q.irq_inhibit[ctrl_q.cr_cnt_sel];
		end
	end

	// ------------------------------------------------------------
	// Zone compare
	// ------------------------------------------------------------
	always_comb begin
		zv     = '0;
		zvalid = 1'b1;
		unique case (ctrl_q.zone_cnt_sel)
			SEL_HW0:  zv     = cnt_q[0];
			SEL_HW1:  zv     = cnt_q[1];
			SEL_SW:   zv     = cnt_q[2];
			SEL_NONE: zvalid = 1'b0;
		endcase
		// Limits assumed ordered by software; reversed limits
		// report below whenever the count is under the low limit
		if ($signed(zv) < $signed(zlo_q)) begin
			zone_d = 3'h1;
		end else if ($signed(zv) > $signed(zhi_q)) begin
			zone_d = 3'h4;
		end else begin
			zone_d = 3'h2;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zone_q <= '0;
		end else if (zvalid) begin
			zone_q <= zone_d;
		end
	end

	// ------------------------------------------------------------
	// Result outputs
	// ------------------------------------------------------------
	// Hardware results override a software write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_q <= `HCR_RST_OUT;
		end else begin
			if (wr_en && paddr == `HCR_OFF_OUT) begin
				out_q <= pwdata[`HCR_OUT_BITS-1:0];
			end
			if (ctrl_q.zone_en & zvalid) begin
				for (int b = 0; b < `HCR_OUT_BITS; b++) begin
					for (int z = 0; z < `HCR_ZONE_BITS; z++) begin
						if (b == int'(ctrl_q.zone_base) + z) begin
							out_q[b] <= zone_d[z];
						end
					end
				end
			end
			if (ctrl_q.cr_en & ~ctrl_q.cr_self & (eq_evt | imm_evt)) begin
				out_q[ctrl_q.cr_out_sel] <= 1'b0;
			end
		end
	end

endmodule : hcr_top

/* File: test/hcr_enc.sv */
// Purpose: Quadrature pulse source for the counter inputs
// Assumes: One quarter step per step request
// Notes:   A leads B when counting up
`timescale 1ns/1ps
module hcr_enc (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic step,
	input  wire logic dir_dn,
	output logic      a,
	output logic      b
);
	logic [1:0] ph_q;

	// ----
	// Gray order: only one line moves per step
	// ----
	assign a = ph_q[1] ^ ph_q[0];
	assign b = ph_q[1];

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			ph_q <= 2'h0;
		else if (step)
			ph_q <= dir_dn ? ph_q - 2'h1 : ph_q + 2'h1;
endmodule : hcr_enc

/* File: test/hcr_sva.sv */
// Purpose: Port-level checks of the compare/reset block
// Assumes: Bound to hcr_top, zero-wait APB
// Notes:   Internal state is not visible here
`timescale 1ns/1ps
`include "hcr_cfg.svh"
module hcr_sva (
	input wire logic                     pclk,
	input wire logic                     presetn,
	input wire logic                     psel,
	input wire logic                     penable,
	input wire logic                     pwrite,
	input wire logic [7:0]               paddr,
	input wire logic [31:0]              prdata,
	input wire logic                     pready,
	input wire logic                     pslverr,
	input wire logic [`HCR_OUT_BITS-1:0] out_q,
	input wire logic                     cmp_irq_q
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ----
	// Bus and result checks
	// ----
	AST_RDY: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	AST_RDY_ONE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_RD_IDLE: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
		else $error("read data outside read access");
	AST_ERR_HI: assert property (pready && paddr > 8'h3C |-> pslverr)
		else $error("unmapped access not refused");
	AST_ERR_LO: assert property
		(pready && paddr <= 8'h3C && paddr[1:0] == 2'h0 |-> !pslverr)
		else $error("mapped access refused");
	AST_ERR_WITH: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_ZONE_HOT: assert property (pready && !pwrite && paddr == 8'h3C
		|-> $onehot(prdata[2:0]) && prdata[31:3] == 29'h0)
		else $error("zone status not one-hot");
	AST_IRQ_ONE: assert property (cmp_irq_q |=> !cmp_irq_q)
		else $error("compare pulse too long");
	AST_OUT_RST: assert property ($rose(presetn) |-> out_q == 8'h00)
		else $error("outputs not clear after reset");

	C_IRQ: cover property (cmp_irq_q);
	C_ERR: cover property (pready && pslverr);
	C_ZONE: cover property (pready && !pwrite && paddr == 8'h3C);
endmodule : hcr_sva

bind hcr_top hcr_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .out_q, .cmp_irq_q);

/* File: test/tb_top.sv */
// Purpose: Self-checking bench for the compare/reset block
// Assumes: Zero-wait APB, pins seen four edges late
// Notes:   Both hardware counters share one encoder
`timescale 1ns/1ps
`include "hcr_cfg.svh"
module tb_top
	import hcr_pkg::*;
;
	logic        pclk = 1'b0, presetn = 1'b0;
	logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00, ze, out_q;
	logic [31:0] pwdata = 32'h0, prdata, xc;
	logic        pready, pslverr, cmp_irq_q, ea, eb;
	logic        step = 1'b0, dn = 1'b0, sw = 1'b0;
	logic [1:0]  ext_rst = 2'h0, cap = 2'h0;
	logic [33:0] mon_e;
	logic [33:0] exp_q[$];
	hcr_pins_s   pins;
	int          miscompares = 0, check_count = 0, irqs = 0;
	int          pos0 = 0, pos1 = 0, r, b;

	always #25 pclk = ~pclk;
	// Start pins unused: internal start stays selected
	assign pins = '{phase_a: {ea, ea}, phase_b: {eb, eb}, ext_reset: ext_rst,
		ext_start: 2'h0, cap_evt: cap, sw_pulse: sw};

	hcr_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pins, .out_q, .cmp_irq_q);
	hcr_enc u_enc (.pclk, .presetn, .step, .dir_dn(dn), .a(ea), .b(eb));

	// ----
	// Tasks
	// ----
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		chk({25'h0, got}, {25'h0, exp});
	endtask : chk8

	task automatic hold(input int c);
		repeat (c) @(posedge pclk);
	endtask : hold

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic e = 1'b0);
		exp_q.push_back({w, e, d});
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? d : 32'h0;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic mv(input int n);
		repeat (n < 0 ? -n : n) begin
			@(posedge pclk);
			step <= 1'b1;
			dn <= n < 0;
			@(posedge pclk);
			step <= 1'b0;
			hold(10);
			pos0 += n < 0 ? -1 : 1;
			pos1 += n < 0 ? -1 : 1;
		end
	endtask : mv

	task automatic xrst;
		ext_rst <= 2'h1;
		hold(8);
		ext_rst <= 2'h0;
		hold(8);
		pos0 = 0;
	endtask : xrst

	task automatic print_verdict;
		if (miscompares == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// ----
	// Result watcher: oldest note against each answer
	// ----
	always @(posedge pclk) begin
		if (cmp_irq_q === 1'b1)
			irqs++;
		if (psel && penable && pready === 1'b1) begin
			mon_e = exp_q.pop_front();
			chk({pslverr, mon_e[33] ? 32'h0 : prdata},
				{mon_e[32], mon_e[33] ? 32'h0 : mon_e[31:0]});
		end
	end

	initial begin
		hold(20000);
		miscompares++;
		print_verdict;
	end

	// ----
	// Scenarios
	// ----
	initial begin
		void'($urandom(32'h25BD98A5));
		r = $urandom % 8;
		b = $urandom % 6;
		xc = `HCR_RST_CTRL | 32'h1 | (r << 2);
		hold(8);
		presetn <= 1'b1;
		apb(0, `HCR_OFF_CTRL, `HCR_RST_CTRL);
		apb(0, `HCR_OFF_G1_MODE, 32'h2);
		apb(0, `HCR_OFF_G4_MODE, 32'h2);
		apb(0, 8'h40, 32'h0, 1'b1);
		apb(1, 8'h40, 32'h5, 1'b1);
		apb(1, `HCR_OFF_G1_MODE, 32'h4);
		apb(1, `HCR_OFF_G4_MODE, 32'h4);
		apb(0, `HCR_OFF_G1_MODE, 32'h4);
		apb(1, `HCR_OFF_CMP, 32'h3);
		apb(1, `HCR_OFF_CTRL, xc);
		apb(1, `HCR_OFF_OUT, 32'hFF);
		mv(3);
		chk8(out_q, ~(8'h1 << r));
		mv(1);
		chk8(out_q, ~(8'h1 << r));
		apb(1, `HCR_OFF_OUT, 32'hFF);
		mv(-1);
		chk8(out_q, ~(8'h1 << r));
		apb(0, `HCR_OFF_CNT0, 32'h3);
		chk8(8'(irqs), 8'h2);
		apb(1, `HCR_OFF_CTRL, xc | 32'h100);
		mv(1);
		mv(-1);
		chk8(8'(irqs), 8'h2);
		apb(1, `HCR_OFF_CMP, 32'h2);
		apb(1, `HCR_OFF_CTRL, `HCR_RST_CTRL | 32'h3);
		apb(1, `HCR_OFF_OUT, 32'hFF);
		mv(-1);
		apb(0, `HCR_OFF_CNT0, 32'h0);
		chk8(out_q, 8'hFF);
		apb(1, `HCR_OFF_CMP, 32'h0);
		apb(1, `HCR_OFF_CTRL, xc & ~32'h200000);
		mv(2);
		apb(1, `HCR_OFF_OUT, 32'hFF);
		xrst;
		apb(0, `HCR_OFF_CNT0, 32'h0);
		chk8(out_q, 8'hFF);
		apb(1, `HCR_OFF_CTRL, xc & ~32'h200000 | 32'h80);
		mv(2);
		apb(1, `HCR_OFF_OUT, 32'hFF);
		xrst;
		chk8(out_q, ~(8'h1 << r));
		apb(1, `HCR_OFF_ZLO, 32'h2);
		apb(1, `HCR_OFF_ZHI, 32'h3);
		apb(1, `HCR_OFF_CTRL, `HCR_RST_CTRL | 32'h800 | (b << 14));
		// Zone bits land one edge after the control write
		hold(2);
		for (int i = 0; i < 5; i++) begin
			ze = pos0 < 2 ? 8'h1 : (pos0 > 3 ? 8'h4 : 8'h2);
			chk8((out_q >> b) & 8'h7, ze);
			apb(0, `HCR_OFF_STATUS, {24'h0, ze});
			mv(1);
		end
		cap <= 2'h3;
		hold(8);
		cap <= 2'h0;
		hold(8);
		apb(0, `HCR_OFF_CAPA_LO, pos0 & 32'hFFFF);
		apb(0, `HCR_OFF_CAPA_HI, pos0 >> 16);
		apb(0, `HCR_OFF_CAPB_LO, pos1 & 32'hFFFF);
		apb(0, `HCR_OFF_CAPB_HI, pos1 >> 16);
		apb(1, `HCR_OFF_CTRL, `HCR_RST_CTRL & ~32'h80000);
		mv(1);
		pos0 -= 1;
		apb(0, `HCR_OFF_CNT0, pos0);
		apb(0, `HCR_OFF_CNT1, pos1);
		apb(1, `HCR_OFF_CTRL, `HCR_RST_CTRL | 32'h20000);
		apb(0, `HCR_OFF_CNT0, 32'h0);
		// Reset bit without its enable must not stop the count
		apb(1, `HCR_OFF_CTRL, `HCR_RST_CTRL | 32'h10000000);
		sw <= 1'b1;
		hold(8);
		sw <= 1'b0;
		hold(8);
		apb(0, `HCR_OFF_CNTSW, 32'h1);
		apb(1, `HCR_OFF_CTRL, `HCR_RST_CTRL | 32'h02000000);
		sw <= 1'b1;
		hold(8);
		apb(0, `HCR_OFF_CNTSW, 32'h1);
		sw <= 1'b0;
		hold(8);
		apb(0, `HCR_OFF_CNTSW, 32'h2);
		apb(1, `HCR_OFF_CTRL, `HCR_RST_CTRL | 32'h04000000);
		sw <= 1'b1;
		hold(8);
		sw <= 1'b0;
		hold(8);
		apb(0, `HCR_OFF_CNTSW, 32'h2);
		apb(1, `HCR_OFF_CTRL, `HCR_RST_CTRL | 32'h14000000);
		apb(0, `HCR_OFF_CNTSW, 32'h0);
		// One full cycle: 1x sees one A rise, 3x misses the B fall
		apb(1, `HCR_OFF_G1_MODE, 32'h1);
		apb(1, `HCR_OFF_G4_MODE, 32'h3);
		mv(4);
		apb(0, `HCR_OFF_CNT0, 32'h1);
		apb(0, `HCR_OFF_CNT1, pos1 - 1);
		print_verdict;
	end
endmodule : tb_top
